// ---- aow_pkg.sv ----
// Constants, register map and carrier types of the output-safety watchdog.
// Assumes a 25 MHz system clock and 32-bit classic Wishbone data.
package aow_pkg;
  localparam int unsigned AOW_CLK_HZ = 25_000_000;
  localparam int unsigned AOW_TICK_MS = 1;
  localparam int unsigned AOW_MS_CYCLES = AOW_CLK_HZ / 1000 * AOW_TICK_MS;
  localparam int unsigned AOW_CHANNELS = 6;
  localparam int unsigned AOW_CODE_W = 13;

  // Register byte offsets
  localparam logic [7:0] AOW_REG_CTRL = 8'h00;
  localparam logic [7:0] AOW_REG_STATUS = 8'h04;
  localparam logic [7:0] AOW_REG_CHAN_EN = 8'h08;
  localparam logic [7:0] AOW_REG_WORK_TMO = 8'h0c;
  localparam logic [7:0] AOW_REG_STORED_TMO = 8'h10;
  localparam logic [7:0] AOW_REG_STORED_RATE = 8'h14;
  localparam logic [7:0] AOW_REG_IRQ_STATUS = 8'h18;
  localparam logic [7:0] AOW_REG_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] AOW_REG_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] AOW_REG_WORK_UNIT = 8'h24;
  localparam logic [7:0] AOW_REG_STORED_UNIT = 8'h28;
  localparam logic [7:0] AOW_REG_CHAN_BASE = 8'h40;

  // Field positions
  localparam int unsigned AOW_CTRL_RESTART = 0;
  localparam int unsigned AOW_ST_TRIPPED = 0;
  localparam int unsigned AOW_ST_SETUP = 1;
  localparam int unsigned AOW_ST_RATE_LSB = 8;
  localparam int unsigned AOW_IRQ_TRIP = 0;
  localparam int unsigned AOW_IRQ_FRAME = 1;
  localparam int unsigned AOW_IRQ_W = 2;

  // Values after reset, setup rate index and highest valid rate index
  localparam logic [15:0] AOW_TMO_DEFAULT_MS = 16'h0032;
  localparam logic [3:0] AOW_RATE_DEFAULT = 4'h9;
  localparam logic [3:0] AOW_RATE_SETUP = 4'h4;
  localparam logic [3:0] AOW_RATE_MAX = 4'hb;

  localparam logic [31:0] AOW_BAUD_TABLE [12] = '{
    32'h0000_2580, 32'h0000_4b00, 32'h0000_9600, 32'h0000_e100,
    32'h0001_c200, 32'h0003_8400, 32'h0007_0800, 32'h000e_1000,
    32'h0013_12d0, 32'h0026_25a0, 32'h004c_4b40, 32'h0098_9680};

  typedef struct packed {
    logic [31:0] unit_id;
    logic [15:0] timeout_ms;
    logic [3:0] rate_index;
  } aow_nv_s;
endpackage

// ---- aow_watchdog.sv ----
// Output-safety watchdog, channel gating and parameter block of the card.
// Assumes a link receiver on i_clock pulsing i_frame_valid per good frame,
// a non-volatile store presenting its contents on i_nv_stored at reset.
// Function
// - A disabled channel drives a zero code whatever value is commanded.
// - After power-up all outputs are zero and all enables off until restart.
// - Host silence longer than the working timeout forces all channels off.
// - The timeout is counted in milliseconds and defaults to 50.
// - A timeout of zero disables the watchdog entirely.
// - Stored parameters are copied to working ones only at power-up.
// - The active timeout is the working value, writable apart from storage.
// - The operate rate index 0 to 11 selects a baud rate from the table.
// - The default operate rate index selects 2.5 megabaud.
// - In setup mode the link runs at 115.2 kilobaud, ignoring the index.
`timescale 1ns/10ps
module aow_watchdog #(
  parameter int unsigned MS_CYCLES = aow_pkg::AOW_MS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_frame_valid,
  input wire logic i_setup_jumper,
  input wire aow_pkg::aow_nv_s i_nv_stored,
  output aow_pkg::aow_nv_s o_nv_stored,
  output logic o_nv_write,
  output logic [aow_pkg::AOW_CHANNELS*aow_pkg::AOW_CODE_W-1:0]
    o_analog_output_channel,
  output logic [aow_pkg::AOW_CHANNELS-1:0] o_drive_enable_switch,
  output logic [31:0] o_link_baud,
  output logic o_setup_mode,
  output logic o_irq
);
  localparam int unsigned NCH = aow_pkg::AOW_CHANNELS;
  localparam int unsigned CW = aow_pkg::AOW_CODE_W;

  initial begin
    if (MS_CYCLES < 1 || MS_CYCLES > 65535) begin
      $error("MS_CYCLES out of range");
    end
  end

  // Wishbone decode
  logic wb_req, wb_wr, ack_ff;
  logic [31:0] wmask;
  assign wb_req = i_wb_cyc & i_wb_stb & ~ack_ff;
  assign wb_wr = wb_req & i_wb_we;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                  {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] din,
                                        input logic [31:0] m);
    merge = (old & ~m) | (din & m);
  endfunction

  logic wr_ctrl, wr_en, wr_wtmo, wr_stmo, wr_srate;
  logic wr_iclr, wr_ien, wr_wunit, wr_sunit, wr_chan;
  logic [2:0] chan_idx;
  assign wr_ctrl = wb_wr && i_wb_adr == aow_pkg::AOW_REG_CTRL;
  assign wr_en = wb_wr && i_wb_adr == aow_pkg::AOW_REG_CHAN_EN;
  assign wr_wtmo = wb_wr && i_wb_adr == aow_pkg::AOW_REG_WORK_TMO;
  assign wr_stmo = wb_wr && i_wb_adr == aow_pkg::AOW_REG_STORED_TMO;
  assign wr_srate = wb_wr && i_wb_adr == aow_pkg::AOW_REG_STORED_RATE;
  assign wr_iclr = wb_wr && i_wb_adr == aow_pkg::AOW_REG_IRQ_CLEAR;
  assign wr_ien = wb_wr && i_wb_adr == aow_pkg::AOW_REG_IRQ_ENABLE;
  assign wr_wunit = wb_wr && i_wb_adr == aow_pkg::AOW_REG_WORK_UNIT;
  assign wr_sunit = wb_wr && i_wb_adr == aow_pkg::AOW_REG_STORED_UNIT;
  assign chan_idx = 3'((i_wb_adr - aow_pkg::AOW_REG_CHAN_BASE) >> 2);
  assign wr_chan = wb_wr && i_wb_adr >= aow_pkg::AOW_REG_CHAN_BASE &&
                   i_wb_adr[1:0] == 2'h0 && chan_idx < 3'(NCH);

  // Setup jumper synchroniser, accepted when stages two and three agree
  logic [2:0] jmp_ff;
  logic setup_ff;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      jmp_ff <= 3'h0;
      setup_ff <= 1'b0;
    end else begin
      jmp_ff <= {jmp_ff[1:0], i_setup_jumper};
      if (jmp_ff[1] == jmp_ff[2]) begin
        setup_ff <= jmp_ff[2];
      end
    end
  end

  // Power-up copy of stored parameters, one cycle after reset release
  logic load_ff, nv_wr_ff;
  aow_pkg::aow_nv_s stored_ff;
  aow_pkg::aow_nv_s work_ff;
  logic [3:0] act_rate_ff;
  always_ff @(posedge i_clock) begin
    load_ff <= i_rst;
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stored_ff <= '{32'h0, aow_pkg::AOW_TMO_DEFAULT_MS,
                     aow_pkg::AOW_RATE_DEFAULT};
    end else if (load_ff) begin
      stored_ff <= i_nv_stored;
    end else begin
      if (wr_stmo) begin
        stored_ff.timeout_ms <= 16'(merge(32'(stored_ff.timeout_ms),
                                          i_wb_dat, wmask));
      end
      if (wr_srate) begin
        stored_ff.rate_index <= 4'(merge(32'(stored_ff.rate_index),
                                         i_wb_dat, wmask));
      end
      if (wr_sunit) begin
        stored_ff.unit_id <= merge(stored_ff.unit_id, i_wb_dat, wmask);
      end
    end
  end
  always_ff @(posedge i_clock) begin
    nv_wr_ff <= ~i_rst & (wr_stmo | wr_srate | wr_sunit);
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      work_ff <= '{32'h0, aow_pkg::AOW_TMO_DEFAULT_MS,
                   aow_pkg::AOW_RATE_DEFAULT};
    end else if (load_ff) begin
      work_ff <= i_nv_stored;
    end else begin
      if (wr_wtmo) begin
        work_ff.timeout_ms <= 16'(merge(32'(work_ff.timeout_ms),
                                        i_wb_dat, wmask));
      end
      if (wr_wunit) begin
        work_ff.unit_id <= merge(work_ff.unit_id, i_wb_dat, wmask);
      end
    end
  end
  // Rate fixed at power-up; out of range index falls back to default
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      act_rate_ff <= aow_pkg::AOW_RATE_DEFAULT;
    end else if (load_ff) begin
      act_rate_ff <= (i_nv_stored.rate_index > aow_pkg::AOW_RATE_MAX) ?
                     aow_pkg::AOW_RATE_DEFAULT :
                     i_nv_stored.rate_index;
    end
  end
  logic [3:0] use_rate;
  assign use_rate = setup_ff ? aow_pkg::AOW_RATE_SETUP : act_rate_ff;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_link_baud <= aow_pkg::AOW_BAUD_TABLE[aow_pkg::AOW_RATE_DEFAULT];
    end else begin
      o_link_baud <= aow_pkg::AOW_BAUD_TABLE[use_rate];
    end
  end

  // Millisecond tick and silence counter
  logic restart, ms_tick, tripped_ff, trip_evt;
  logic [15:0] div_ff;
  logic [16:0] ms_ff;
  assign restart = wr_ctrl & i_wb_sel[0] &
                   i_wb_dat[aow_pkg::AOW_CTRL_RESTART];
  assign ms_tick = div_ff == 16'(MS_CYCLES - 1);
  always_ff @(posedge i_clock) begin
    if (i_rst || i_frame_valid || restart || ms_tick) begin
      div_ff <= 16'h0;
    end else begin
      div_ff <= div_ff + 16'h1;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst || i_frame_valid || restart) begin
      ms_ff <= 17'h0;
    end else if (ms_tick && ms_ff != 17'h1ffff) begin
      ms_ff <= ms_ff + 17'h1;
    end
  end
  assign trip_evt = ~tripped_ff && work_ff.timeout_ms != 16'h0 &&
                    ms_ff > {1'b0, work_ff.timeout_ms};
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tripped_ff <= 1'b1;
    end else if (trip_evt) begin
      tripped_ff <= 1'b1;
    end else if (restart) begin
      tripped_ff <= 1'b0;
    end
  end

  // Channel commands and gated outputs
  logic [NCH-1:0] en_ff;
  logic [CW-1:0] code_ff [NCH];
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      en_ff <= '0;
    end else if (wr_en) begin
      en_ff <= NCH'(merge(32'(en_ff), i_wb_dat, wmask));
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int i = 0; i < NCH; i++) begin
        code_ff[i] <= '0;
      end
    end else if (wr_chan) begin
      code_ff[chan_idx] <= CW'(merge(32'(code_ff[chan_idx]),
                                     i_wb_dat, wmask));
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_drive_enable_switch <= '0;
      o_analog_output_channel <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        o_drive_enable_switch[i] <= en_ff[i] & ~tripped_ff;
        o_analog_output_channel[i*CW +: CW] <=
          (en_ff[i] & ~tripped_ff) ? code_ff[i] : '0;
      end
    end
  end

  // Interrupts: set wins over clear
  logic [aow_pkg::AOW_IRQ_W-1:0] ist_ff, ien_ff, iset, iclr;
  assign iset = {i_frame_valid, trip_evt};
  assign iclr = wr_iclr ? aow_pkg::AOW_IRQ_W'(i_wb_dat & wmask) : '0;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ist_ff <= '0;
    end else begin
      ist_ff <= (ist_ff & ~iclr) | iset;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ien_ff <= '0;
    end else if (wr_ien) begin
      ien_ff <= aow_pkg::AOW_IRQ_W'(merge(32'(ien_ff), i_wb_dat, wmask));
    end
  end
  assign o_irq = |(ist_ff & ien_ff);

  // Read mux and acknowledge
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0;
    case (i_wb_adr)
      aow_pkg::AOW_REG_STATUS: begin
        rd[aow_pkg::AOW_ST_TRIPPED] = tripped_ff;
        rd[aow_pkg::AOW_ST_SETUP] = setup_ff;
        rd[aow_pkg::AOW_ST_RATE_LSB +: 4] = use_rate;
      end
      aow_pkg::AOW_REG_CHAN_EN: rd = 32'(en_ff);
      aow_pkg::AOW_REG_WORK_TMO: rd = 32'(work_ff.timeout_ms);
      aow_pkg::AOW_REG_STORED_TMO: rd = 32'(stored_ff.timeout_ms);
      aow_pkg::AOW_REG_STORED_RATE: rd = 32'(stored_ff.rate_index);
      aow_pkg::AOW_REG_IRQ_STATUS: rd = 32'(ist_ff);
      aow_pkg::AOW_REG_IRQ_ENABLE: rd = 32'(ien_ff);
      aow_pkg::AOW_REG_WORK_UNIT: rd = work_ff.unit_id;
      aow_pkg::AOW_REG_STORED_UNIT: rd = stored_ff.unit_id;
      default: begin
        if (i_wb_adr >= aow_pkg::AOW_REG_CHAN_BASE &&
            i_wb_adr[1:0] == 2'h0 && chan_idx < 3'(NCH)) begin
          rd = 32'(code_ff[chan_idx]);
        end
      end
    endcase
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      ack_ff <= wb_req;
      o_wb_dat <= wb_req ? rd : 32'h0;
    end
  end
  assign o_wb_ack = ack_ff;
  assign o_nv_stored = stored_ff;
  assign o_nv_write = nv_wr_ff;
  assign o_setup_mode = setup_ff;

  // Checks
  sequence s_silence;
    ~i_frame_valid & ~restart & ~tripped_ff;
  endsequence
  property p_disabled_zero;
    @(posedge i_clock) disable iff (i_rst)
    ~en_ff[0] |=> o_analog_output_channel[CW-1:0] == '0;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero)
    else $error("disabled channel not at zero");
  property p_tripped_off;
    @(posedge i_clock) disable iff (i_rst)
    tripped_ff |=> o_drive_enable_switch == '0 &&
                   o_analog_output_channel == '0;
  endproperty
  a_tripped_off: assert property (p_tripped_off)
    else $error("outputs live while tripped");
  property p_trip_on_silence;
    @(posedge i_clock) disable iff (i_rst)
    trip_evt |=> tripped_ff ##1 o_drive_enable_switch == '0;
  endproperty
  a_trip_on_silence: assert property (p_trip_on_silence)
    else $error("timeout did not force outputs off");
  property p_trip_cause;
    @(posedge i_clock) disable iff (i_rst)
    $rose(tripped_ff) |-> $past(ms_ff) > {1'b0, $past(work_ff.timeout_ms)};
  endproperty
  a_trip_cause: assert property (p_trip_cause)
    else $error("trip before timeout elapsed");
  property p_zero_disables;
    @(posedge i_clock) disable iff (i_rst)
    work_ff.timeout_ms == 16'h0 && ~tripped_ff |=> ~tripped_ff;
  endproperty
  a_zero_disables: assert property (p_zero_disables)
    else $error("watchdog tripped while disabled");
  property p_rate_stable;
    @(posedge i_clock) disable iff (i_rst)
    ~load_ff ##1 ~load_ff |-> $stable(act_rate_ff);
  endproperty
  a_rate_stable: assert property (p_rate_stable)
    else $error("active rate changed after power-up");
  property p_work_tmo_write;
    @(posedge i_clock) disable iff (i_rst)
    wr_wtmo && i_wb_sel == 4'hf && ~load_ff |=>
      work_ff.timeout_ms == $past(i_wb_dat[15:0]);
  endproperty
  a_work_tmo_write: assert property (p_work_tmo_write)
    else $error("working timeout not written");
  property p_setup_rate;
    @(posedge i_clock) disable iff (i_rst)
    setup_ff ##1 setup_ff |-> o_link_baud ==
      aow_pkg::AOW_BAUD_TABLE[aow_pkg::AOW_RATE_SETUP];
  endproperty
  a_setup_rate: assert property (p_setup_rate)
    else $error("setup mode rate wrong");
  property p_frame_restarts;
    @(posedge i_clock) disable iff (i_rst)
    i_frame_valid ##1 s_silence |-> ms_ff == 17'h0 ##1 ms_ff <= 17'h1;
  endproperty
  a_frame_restarts: assert property (p_frame_restarts)
    else $error("frame did not restart the count");
endmodule

// ---- aow_host_model.sv ----
// Far-side model: host link frame source and the non-volatile store.
// Assumes the card samples i_nv_stored at the edge after reset release.
`timescale 1ns/10ps
module aow_host_model (
  input wire logic i_clock,
  input wire logic i_frames_on,
  input wire logic [7:0] i_period,
  input wire logic i_preset,
  input wire aow_pkg::aow_nv_s i_preset_val,
  input wire logic i_nv_write,
  input wire aow_pkg::aow_nv_s i_nv_data,
  output aow_pkg::aow_nv_s o_nv_image,
  output logic o_frame_valid
);
  logic [7:0] gap_ff = 8'h00;

  // One good frame every i_period cycles while traffic is on
  always_ff @(posedge i_clock) begin
    if (!i_frames_on || gap_ff == i_period - 8'h01) gap_ff <= 8'h00;
    else gap_ff <= gap_ff + 8'h01;
    o_frame_valid <= i_frames_on && gap_ff == i_period - 8'h01;
  end

  // No firmware image is ever pushed to the card from here
  // Image outlives card resets; changes only on i_preset or the persist strobe
  always_ff @(posedge i_clock) begin
    if (i_preset) o_nv_image <= i_preset_val;
    else if (i_nv_write) o_nv_image <= i_nv_data;
  end
endmodule

// ---- test_analog_output_safety_watchdog.sv ----
// Self-checking bench for the output-safety watchdog block.
// Assumes aow_pkg, aow_watchdog and aow_host_model are compiled first.
`timescale 1ns/10ps
module test_analog_output_safety_watchdog;
  localparam int unsigned MSC = 10;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, baud;
  logic ack, frame, nv_wr, setup, irq;
  logic jumper = 1'b0;
  logic frames_on = 1'b0;
  logic preset = 1'b0;
  logic [7:0] period = 8'h23;
  aow_pkg::aow_nv_s preset_val = '0;
  aow_pkg::aow_nv_s nv_out, nv_img;
  logic [77:0] analog_output_channel;
  logic [5:0] ena;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int n_checks = 0;

  aow_watchdog #(.MS_CYCLES(MSC)) i_dut (
    .i_clock(clock), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_frame_valid(frame),
    .i_setup_jumper(jumper), .i_nv_stored(nv_img), .o_nv_stored(nv_out),
    .o_nv_write(nv_wr), .o_analog_output_channel(analog_output_channel),
    .o_drive_enable_switch(ena), .o_link_baud(baud),
    .o_setup_mode(setup), .o_irq(irq));
  aow_host_model i_host (
    .i_clock(clock), .i_frames_on(frames_on), .i_period(period),
    .i_preset(preset), .i_preset_val(preset_val), .i_nv_write(nv_wr),
    .i_nv_data(nv_out), .o_nv_image(nv_img), .o_frame_valid(frame));

  initial begin
    forever #20 clock = ~clock;
  end

  task automatic fail(input string msg);
    n_mismatch++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic chk(input logic [77:0] got, input logic [77:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) fail(what);
  endtask

  task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("read %h want %h", got, exp));
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) fail("no bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic do_reset(input aow_pkg::aow_nv_s nv);
    @(posedge clock);
    rst <= 1'b1;
    preset <= 1'b1;
    preset_val <= nv;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    preset <= 1'b0;
    wait_cyc(4);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Read data matched in issue order as each read is acknowledged
  always @(posedge clock) begin
    if (ack === 1'b1 && cyc && !we) begin
      if (exp_q.size() == 0) fail("read with no expectation");
      else chk_read(rdat, exp_q.pop_front());
    end
  end

  initial begin
    #(40 * 20000);
    fail("run timeout");
    summarize();
  end

  initial begin
    aow_pkg::aow_nv_s nv;
    logic [12:0] code [6];
    logic [5:0] en;
    logic [77:0] exp_a;
    int k;
    void'($urandom(60));
    // Every stored rate index, then out-of-range ones
    for (int i = 0; i < 16; i++) begin
      k = (i < 12) ? i : 9;
      nv = '{unit_id: $urandom(), timeout_ms: 16'h0032, rate_index: 4'(i)};
      do_reset(nv);
      chk(78'(baud), 78'(aow_pkg::AOW_BAUD_TABLE[k]), "rate");
      if (i == 9) chk(78'(baud), 78'h26_25a0, "default rate");
      chk({72'h0, ena}, 78'h0, "enables at power-up");
      chk(analog_output_channel, 78'h0, "outputs at power-up");
      rd(8'h04, 32'h0000_0001 | (32'(k) << 8));
      rd(8'h24, nv.unit_id);
      rd(8'h0c, 32'h0000_0032);
    end
    $display("rate table test done");
    @(posedge clock) jumper <= 1'b1;
    wait_cyc(8);
    chk(78'(baud), 78'(aow_pkg::AOW_BAUD_TABLE[4]), "setup rate");
    chk(78'(setup), 78'h1, "setup flag");
    rd(8'h04, 32'h0000_0403);
    wr(8'h10, 32'h0000_0064);
    wr(8'h14, 32'h0000_0002);
    @(posedge clock) jumper <= 1'b0;
    wait_cyc(8);
    $display("setup mode test done");
    chk(78'(nv_img.timeout_ms), 78'h64, "persisted timeout");
    chk(78'(baud), 78'(aow_pkg::AOW_BAUD_TABLE[9]), "rate held");
    rd(8'h0c, 32'h0000_0032);
    do_reset(nv_img);
    chk(78'(baud), 78'(aow_pkg::AOW_BAUD_TABLE[2]), "new rate");
    rd(8'h0c, 32'h0000_0064);
    wr(8'h0c, 32'h0000_0003);
    rd(8'h0c, 32'h0000_0003);
    $display("parameter test done");
    for (int c = 0; c < 6; c++) begin
      code[c] = 13'($urandom());
      wr(8'h40 + 8'(4 * c), {19'h0, code[c]});
    end
    en = 6'($urandom()) | 6'h01;
    en[1 + $urandom() % 5] = 1'b0;
    wr(8'h08, {26'h0, en});
    wait_cyc(2);
    chk({72'h0, ena}, 78'h0, "armed before restart");
    exp_a = '0;
    for (int c = 0; c < 6; c++) if (en[c]) exp_a[13 * c +: 13] = code[c];
    @(posedge clock) frames_on <= 1'b1;
    wr(8'h00, 32'h0000_0001);
    wait_cyc(2);
    chk({72'h0, ena}, {72'h0, en}, "enables after restart");
    chk(analog_output_channel, exp_a, "gated outputs");
    wr(8'h08, {26'h0, en & 6'h3e});
    wait_cyc(2);
    chk(78'(analog_output_channel[12:0]), 78'h0, "disabled channel");
    wr(8'h08, {26'h0, en});
    $display("gating test done");
    wr(8'h1c, 32'h0000_0003);
    wr(8'h20, 32'h0000_0001);
    wait_cyc(200);
    chk({72'h0, ena}, {72'h0, en}, "fed watchdog");
    chk(78'(irq), 78'h0, "masked frame event");
    rd(8'h18, 32'h0000_0002);
    @(posedge clock) frames_on <= 1'b0;
    wait_cyc(60);
    chk({72'h0, ena}, 78'h0, "tripped enables");
    chk(analog_output_channel, 78'h0, "tripped outputs");
    chk(78'(irq), 78'h1, "trip interrupt");
    rd(8'h04, 32'h0000_0201);
    @(posedge clock) frames_on <= 1'b1;
    wait_cyc(80);
    chk({72'h0, ena}, 78'h0, "trip holds");
    wr(8'h1c, 32'h0000_0001);
    wait_cyc(2);
    chk(78'(irq), 78'h0, "interrupt cleared");
    wr(8'h00, 32'h0000_0001);
    wait_cyc(2);
    chk({72'h0, ena}, {72'h0, en}, "rearmed");
    $display("watchdog test done");
    wr(8'h0c, 32'h0000_0000);
    @(posedge clock) frames_on <= 1'b0;
    wait_cyc(300);
    chk({72'h0, ena}, {72'h0, en}, "watchdog off");
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    $display("disable and unmapped test done");
    summarize();
  end
endmodule
